// ---- hdl/mse_defines.svh ----
`ifndef MSE_DEFINES_SVH
`define MSE_DEFINES_SVH
// ----------------------------------------
// register byte addresses (index times four)
// ----------------------------------------
`define MSE_IDX_DMA_SEG 8'hf9
`define MSE_IDX_CODE_SEG 8'hf4
`define MSE_IDX_INT_SEG 8'hf8
`define MSE_IDX_EXT_MODE 8'hf6
`define MSE_IDX_PAGE0 8'hf0
`define MSE_IDX_PORT0 8'he0
`define MSE_ADDR_DMA_SEG 12'h3e4
`define MSE_ADDR_CODE_SEG 12'h3d0
`define MSE_ADDR_INT_SEG 12'h3e0
`define MSE_ADDR_EXT_MODE 12'h3d8
`define MSE_ADDR_LOW_BANK 12'h380
`define MSE_ADDR_HIGH_BANK 12'h3c0
`define MSE_ADDR_STATUS 12'h400
// ----------------------------------------
// fields
// ----------------------------------------
`define MSE_SEG_W 6
`define MSE_BIT_REMAP 5
`define MSE_BIT_SAVE 6
`define MSE_PAGE_OFS_W 14
`define MSE_BANK_MASK 12'hff0
`define MSE_RESP_OKAY 2'b00
`define MSE_RESP_SLVERR 2'b10
`define MSE_ZERO_BYTE 8'h00
`define MSE_ZERO_SEG 6'h00
`endif

// ---- hdl/mse_page_bank.sv ----
`timescale 1ns/1ps
`include "mse_defines.svh"
// four byte registers, registered read, one write port
module mse_page_bank (
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset, low
    input wire logic wr_en, // write strobe
    input wire logic [1:0] wr_idx, // write index
    input wire logic [7:0] wr_data, // write byte
    input wire logic [1:0] rd_idx, // read index
    output logic [7:0] rd_data, // registered read byte
    output logic [31:0] all_data // all four bytes, live
);
    logic [7:0] mem [0:3];

    assign all_data = {mem[3], mem[2], mem[1], mem[0]};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mem[0] <= `MSE_ZERO_BYTE;
            mem[1] <= `MSE_ZERO_BYTE;
            mem[2] <= `MSE_ZERO_BYTE;
            mem[3] <= `MSE_ZERO_BYTE;
            rd_data <= `MSE_ZERO_BYTE;
        end
        else
        begin
            if (wr_en)
                mem[wr_idx] <= wr_data;
            rd_data <= mem[rd_idx];
        end
    end
endmodule

// ---- hdl/mse_pkg.sv ----
package mse_pkg;
    typedef enum logic [1:0] {
        MSE_ACC_DATA = 2'b00,
        MSE_ACC_FETCH = 2'b01,
        MSE_ACC_DMA = 2'b10
    } mse_acc_t;

    typedef struct packed {
        logic valid;
        mse_acc_t kind;
        logic [15:0] vaddr;
        logic periph_seg;
    } mse_req_t;

    typedef struct packed {
        logic valid;
        logic [21:0] paddr;
    } mse_resp_t;

    typedef enum logic [1:0] {
        MSE_CTX_NORMAL = 2'b00,
        MSE_CTX_COMPAT = 2'b01,
        MSE_CTX_EXTENDED = 2'b10
    } mse_ctx_t;
endpackage

// ---- hdl/mse_top.sv ----
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "mse_defines.svh"
module mse_top (
    input wire logic aclk, // clock, 25 mhz
    input wire logic aresetn, // sync reset, low
    // axi4-lite slave
    input wire logic [11:0] s_awaddr, // write address
    input wire logic s_awvalid, // write address valid
    output logic s_awready, // write address ready
    input wire logic [31:0] s_wdata, // write data
    input wire logic [3:0] s_wstrb, // byte strobes
    input wire logic s_wvalid, // write data valid
    output logic s_wready, // write data ready
    output logic [1:0] s_bresp, // write response
    output logic s_bvalid, // write response valid
    input wire logic s_bready, // write response ready
    input wire logic [11:0] s_araddr, // read address
    input wire logic s_arvalid, // read address valid
    output logic s_arready, // read address ready
    output logic [31:0] s_rdata, // read data
    output logic [1:0] s_rresp, // read response
    output logic s_rvalid, // read data valid
    input wire logic s_rready, // read data ready
    // core and dma side
    input wire mse_pkg::mse_req_t req, // translation request
    output mse_pkg::mse_resp_t resp, // physical address, one cycle later
    input wire logic far_load, // far jump/call/return loads code segment
    input wire logic [5:0] far_seg, // segment for far_load
    input wire logic int_enter, // interrupt entry pulse
    input wire logic int_return, // interrupt return pulse
    input wire logic [5:0] popped_seg, // code segment popped by return
    output logic [5:0] push_seg, // code segment to push on entry
    output logic push_seg_valid, // entry pushes a code segment
    output logic [21:0] vector_base, // vector table segment base
    output logic [1:0] context_state // current execution context
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] dma_memory_segment;
    logic [5:0] code_segment_reg;
    logic [5:0] interrupt_segment_reg;
    logic [7:0] extended_mode_reg_two;
    mse_pkg::mse_ctx_t ctx;
    mse_pkg::mse_ctx_t next_ctx;
    logic [11:0] aw_addr;
    logic aw_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_have;

    wire page_reg_remap = extended_mode_reg_two[`MSE_BIT_REMAP];
    wire segment_save_enable = extended_mode_reg_two[`MSE_BIT_SAVE];

    function automatic logic in_bank(input logic [11:0] a);
        in_bank = (a & `MSE_BANK_MASK) == `MSE_ADDR_LOW_BANK || (a & `MSE_BANK_MASK) == `MSE_ADDR_HIGH_BANK;
    endfunction

    // remap moves the page registers to the low bank, ports take the high one
    function automatic logic in_pages(input logic [11:0] a, input logic remap);
        in_pages = (a & `MSE_BANK_MASK) == (remap ? `MSE_ADDR_LOW_BANK : `MSE_ADDR_HIGH_BANK);
    endfunction

    // ----------------------------------------
    // write channel: address and data in either order
    // ----------------------------------------
    wire wr_fire = aw_have && w_have && !s_bvalid;
    wire wr_lane0 = wr_fire && w_strb[0];
    wire wr_bank = in_bank(aw_addr);
    wire wr_page_hit = wr_lane0 && in_pages(aw_addr, page_reg_remap);
    wire wr_code = wr_lane0 && aw_addr == `MSE_ADDR_CODE_SEG;
    wire wr_ok = wr_bank || aw_addr == `MSE_ADDR_CODE_SEG || aw_addr == `MSE_ADDR_INT_SEG
                 || aw_addr == `MSE_ADDR_EXT_MODE || aw_addr == `MSE_ADDR_DMA_SEG;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_bvalid <= 1'b0;
            s_bresp <= `MSE_RESP_OKAY;
            s_awready <= 1'b1;
            s_wready <= 1'b1;
        end
        else
        begin
            // readies are flops: each drops on its own handshake, both return when the response is accepted
            if (s_awvalid && s_awready)
            begin
                aw_have <= 1'b1;
                aw_addr <= s_awaddr;
                s_awready <= 1'b0;
            end
            if (s_wvalid && s_wready)
            begin
                w_have <= 1'b1;
                w_data <= s_wdata;
                w_strb <= s_wstrb;
                s_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= wr_ok ? `MSE_RESP_OKAY : `MSE_RESP_SLVERR;
            end
            else if (s_bvalid && s_bready)
            begin
                s_bvalid <= 1'b0;
                s_awready <= 1'b1;
                s_wready <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // page registers and port data registers
    // ----------------------------------------
    logic [7:0] page_rd;
    logic [31:0] page_all;
    logic [31:0] port_data;
    logic [1:0] rd_idx_q;

    mse_page_bank u_pages (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(wr_page_hit),
        .wr_idx(aw_addr[3:2]),
        .wr_data(w_data[7:0]),
        .rd_idx(s_araddr[3:2]),
        .rd_data(page_rd),
        .all_data(page_all)
    );

    // port data registers swap places with the page registers
    wire wr_port_hit = wr_lane0 && wr_bank && !wr_page_hit && aw_addr[5:4] == 2'b00;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            port_data <= 32'h0000_0000;
        else if (wr_port_hit)
            port_data[aw_addr[3:2]*8 +: 8] <= w_data[7:0];
    end

    // ----------------------------------------
    // segment and mode registers
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dma_memory_segment <= `MSE_ZERO_BYTE;
            interrupt_segment_reg <= `MSE_ZERO_SEG;
            extended_mode_reg_two <= `MSE_ZERO_BYTE;
        end
        else if (wr_lane0)
        begin
            if (aw_addr == `MSE_ADDR_DMA_SEG)
                dma_memory_segment <= w_data[7:0];
            else if (aw_addr == `MSE_ADDR_INT_SEG)
                interrupt_segment_reg <= w_data[5:0];
            else if (aw_addr == `MSE_ADDR_EXT_MODE)
                extended_mode_reg_two <= w_data[7:0];
        end
    end

    // ----------------------------------------
    // interrupt context and code segment
    // ----------------------------------------
    always_comb
    begin
        next_ctx = ctx;
        if (int_enter)
            next_ctx = segment_save_enable ? mse_pkg::MSE_CTX_EXTENDED : mse_pkg::MSE_CTX_COMPAT;
        else if (int_return)
            next_ctx = mse_pkg::MSE_CTX_NORMAL;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctx <= mse_pkg::MSE_CTX_NORMAL;
            code_segment_reg <= `MSE_ZERO_SEG;
            push_seg <= `MSE_ZERO_SEG;
            push_seg_valid <= 1'b0;
        end
        else
        begin
            ctx <= next_ctx;
            push_seg_valid <= int_enter && segment_save_enable;
            if (int_enter && segment_save_enable)
            begin
                push_seg <= code_segment_reg;
                code_segment_reg <= interrupt_segment_reg;
            end
            else if (int_return && ctx == mse_pkg::MSE_CTX_EXTENDED)
                code_segment_reg <= popped_seg;
            else if (far_load)
                code_segment_reg <= far_seg;
            else if (wr_code)
                code_segment_reg <= w_data[5:0];
        end
    end

    // ----------------------------------------
    // translation
    // ----------------------------------------
    // compatible routine fetches ignore the code segment entirely
    wire [5:0] fetch_seg = ctx == mse_pkg::MSE_CTX_COMPAT
                           ? interrupt_segment_reg : code_segment_reg;
    // sampled per access, so a changed select hits the next transfer
    wire [5:0] dma_seg = req.periph_seg
                         ? dma_memory_segment[5:0] : interrupt_segment_reg;
    wire [7:0] data_page = page_all[req.vaddr[15:14]*8 +: 8];
    wire [21:0] data_addr = {data_page, req.vaddr[`MSE_PAGE_OFS_W-1:0]};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            resp <= '0;
            vector_base <= 22'h00_0000;
            context_state <= 2'b00;
        end
        else
        begin
            resp.valid <= req.valid;
            vector_base <= {interrupt_segment_reg, 16'h0000};
            context_state <= next_ctx;
            if (req.kind == mse_pkg::MSE_ACC_FETCH)
                resp.paddr <= {fetch_seg, req.vaddr};
            else if (req.kind == mse_pkg::MSE_ACC_DMA)
                resp.paddr <= {dma_seg, req.vaddr};
            else
                resp.paddr <= data_addr;
        end
    end

    // ----------------------------------------
    // read channel, one cycle to answer
    // ----------------------------------------
    logic [11:0] ar_q;
    logic rd_pend;
    wire rd_bank = in_bank(ar_q);
    wire rd_page = in_pages(ar_q, page_reg_remap);
    wire [7:0] rd_byte = rd_page ? page_rd
                       : (rd_bank && ar_q[5:4] == 2'b00) ? port_data[rd_idx_q*8 +: 8]
                       : ar_q == `MSE_ADDR_DMA_SEG ? dma_memory_segment
                       : ar_q == `MSE_ADDR_CODE_SEG ? {2'b00, code_segment_reg}
                       : ar_q == `MSE_ADDR_INT_SEG ? {2'b00, interrupt_segment_reg}
                       : ar_q == `MSE_ADDR_EXT_MODE ? extended_mode_reg_two
                       : ar_q == `MSE_ADDR_STATUS ? {6'h00, context_state}
                       : `MSE_ZERO_BYTE;
    wire rd_ok = rd_bank || ar_q == `MSE_ADDR_DMA_SEG || ar_q == `MSE_ADDR_CODE_SEG
                 || ar_q == `MSE_ADDR_INT_SEG || ar_q == `MSE_ADDR_EXT_MODE || ar_q == `MSE_ADDR_STATUS;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ar_q <= 12'h000;
            rd_idx_q <= 2'b00;
            rd_pend <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0000_0000;
            s_rresp <= `MSE_RESP_OKAY;
            s_arready <= 1'b1;
        end
        else
        begin
            if (s_arvalid && s_arready)
            begin
                ar_q <= s_araddr;
                rd_idx_q <= s_araddr[3:2];
                rd_pend <= 1'b1;
                s_arready <= 1'b0;
            end
            if (rd_pend)
            begin
                rd_pend <= 1'b0;
                s_rvalid <= 1'b1;
                s_rdata <= {24'h00_0000, rd_byte};
                s_rresp <= rd_ok ? `MSE_RESP_OKAY : `MSE_RESP_SLVERR;
            end
            else if (s_rvalid && s_rready)
            begin
                s_rvalid <= 1'b0;
                s_arready <= 1'b1;
            end
        end
    end
endmodule

// ---- tb/mse_core_model.sv ----
`timescale 1ns/1ps
// ----
// core and dma requester
// ----
module mse_core_model (
    input wire logic aclk, // clock
    output mse_pkg::mse_req_t req, // translation request
    output logic far_load, // far load strobe
    output logic [5:0] far_seg, // far segment
    output logic int_enter, // entry strobe
    output logic int_return, // return strobe
    output logic [5:0] popped_seg // popped segment
);
    initial
    begin
        req = '0;
        {far_load, int_enter, int_return} = 3'b000;
        far_seg = 6'h00;
        popped_seg = 6'h00;
    end
    // offsets are 16 bits, so a procedure never leaves its segment
    task automatic issue(input mse_pkg::mse_acc_t k, input logic [15:0] va, input logic ps);
        @(posedge aclk);
        req <= '{1'b1, k, va, ps};
        @(posedge aclk);
        // released address and select lines flip (kind is kept) so a stale value never passes for a live one
        req <= '{1'b0, k, ~va, ~ps};
        #1;
    endtask
    // sel is far, enter, return; s drives both far_seg and popped_seg
    task automatic strobe(input logic [2:0] sel, input logic [5:0] s);
        @(posedge aclk);
        {far_load, int_enter, int_return} <= sel;
        far_seg <= s;
        popped_seg <= s;
        @(posedge aclk);
        {far_load, int_enter, int_return} <= 3'b000;
        far_seg <= ~s;
        popped_seg <= ~s;
        #1;
    endtask
endmodule

// ---- tb/mse_top_asserts.sv ----
`timescale 1ns/1ps
module mse_top_asserts (
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset, low
    input wire mse_pkg::mse_req_t req, // request
    input wire mse_pkg::mse_resp_t resp, // answer
    input wire logic far_load, // far load strobe
    input wire logic [5:0] far_seg, // far segment
    input wire logic int_enter, // entry strobe
    input wire logic int_return, // return strobe
    input wire logic [5:0] popped_seg, // popped segment
    input wire logic push_seg_valid, // push strobe
    input wire logic [21:0] vector_base, // vector base
    input wire logic [1:0] context_state // context
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ----
    // translation
    // ----
    property p_data_ofs;
        req.valid && req.kind == mse_pkg::MSE_ACC_DATA |=> resp.paddr[13:0] == $past(req.vaddr[13:0]);
    endproperty
    a_data_ofs: assert property (p_data_ofs) else $error("data offset wrong");
    property p_fetch_ofs;
        req.valid && req.kind == mse_pkg::MSE_ACC_FETCH |=> resp.valid && resp.paddr[15:0] == $past(req.vaddr);
    endproperty
    a_fetch_ofs: assert property (p_fetch_ofs) else $error("fetch offset wrong");
    property p_dma_int;
        req.valid && req.kind == mse_pkg::MSE_ACC_DMA && !req.periph_seg
            |=> resp.paddr == {vector_base[21:16], $past(req.vaddr)};
    endproperty
    a_dma_int: assert property (p_dma_int) else $error("dma segment wrong");
    // compatible routine fetches from the interrupt segment whatever far loads did
    property p_compat;
        req.valid && req.kind == mse_pkg::MSE_ACC_FETCH && context_state == mse_pkg::MSE_CTX_COMPAT
            |=> resp.paddr[21:16] == vector_base[21:16];
    endproperty
    a_compat: assert property (p_compat) else $error("compat fetch segment wrong");
    property p_far;
        far_load && !int_enter && !int_return && context_state != mse_pkg::MSE_CTX_COMPAT
            ##2 (req.valid && req.kind == mse_pkg::MSE_ACC_FETCH && !int_enter && !int_return)
            |=> resp.paddr[21:16] == $past(far_seg, 3);
    endproperty
    a_far: assert property (p_far) else $error("far load not used");
    // ----
    // interrupts
    // ----
    property p_push;
        push_seg_valid |-> $past(int_enter) && context_state == mse_pkg::MSE_CTX_EXTENDED;
    endproperty
    a_push: assert property (p_push) else $error("push without extended entry");
    property p_return;
        int_return && !int_enter |=> context_state == mse_pkg::MSE_CTX_NORMAL;
    endproperty
    a_return: assert property (p_return) else $error("return left context");
    property p_restore;
        context_state == mse_pkg::MSE_CTX_EXTENDED && int_return && !int_enter
            ##2 (req.valid && req.kind == mse_pkg::MSE_ACC_FETCH && !far_load && !int_enter)
            |=> resp.paddr[21:16] == $past(popped_seg, 3);
    endproperty
    a_restore: assert property (p_restore) else $error("segment not restored");
endmodule
bind mse_top mse_top_asserts u_asserts (.*);

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`include "mse_defines.svh"
module tb;
    logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, s_awready, s_wready;
    logic s_bvalid, s_arready, s_rvalid, far_load, int_enter, int_return, push_seg_valid;
    logic [11:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp, context_state;
    logic [5:0] far_seg, popped_seg, push_seg;
    logic [21:0] vector_base;
    mse_pkg::mse_req_t req;
    mse_pkg::mse_resp_t resp;
    int mismatches = 0;
    int n_checks = 0;
    logic [7:0] pg [4] = '{8'h11, 8'h22, 8'h33, 8'hc4};
    logic [11:0] ra [6] = '{`MSE_ADDR_DMA_SEG, `MSE_ADDR_CODE_SEG, `MSE_ADDR_INT_SEG, `MSE_ADDR_EXT_MODE,
        `MSE_ADDR_HIGH_BANK, `MSE_ADDR_STATUS};
    mse_top DUT (.*);
    mse_core_model core (.*);
    // ----
    // helpers
    // ----
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic pa;
        logic pw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        {s_awvalid, s_wvalid, s_bready} <= 3'b111;
        while (pa || pw)
        begin
            @(posedge aclk);
            pa = pa && !s_awready;
            pw = pw && !s_wready;
            s_awvalid <= pa;
            s_wvalid <= pw;
        end
        do @(posedge aclk); while (!s_bvalid);
        s_bready <= 1'b0;
        chk(32'(s_bresp), 32'(er));
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_araddr <= a;
        {s_arvalid, s_rready} <= 2'b11;
        do @(posedge aclk); while (!s_arready);
        s_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_rvalid);
        s_rready <= 1'b0;
        chk(s_rdata, ed);
        chk(32'(s_rresp), 32'(er));
    endtask
    task automatic xl(input mse_pkg::mse_acc_t k, input logic [15:0] va, input logic ps, input logic [21:0] e);
        core.issue(k, va, ps);
        chk(32'(resp.valid), 32'h1);
        chk(32'(resp.paddr), 32'(e));
    endtask
    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // far more than the sequence needs, so only a hang gets here
    initial
    begin
        #(40 * 5000);
        mismatches++;
        wrap_up();
    end
    // ----
    // tests
    // ----
    initial
    begin
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'b00000;
        s_awaddr = 12'h000;
        s_araddr = 12'h000;
        s_wdata = 32'h0;
        s_wstrb = 4'hf;
        aresetn = 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (ra[i]) rd(ra[i], 32'h0, `MSE_RESP_OKAY);
        rd(12'h010, 32'h0, `MSE_RESP_SLVERR);
        $display("test reset done");
        wr(`MSE_ADDR_DMA_SEG, 32'h2a, `MSE_RESP_OKAY);
        wr(`MSE_ADDR_INT_SEG, 32'h15, `MSE_RESP_OKAY);
        foreach (pg[i]) wr(`MSE_ADDR_HIGH_BANK + 12'(4 * i), 32'(pg[i]), `MSE_RESP_OKAY);
        wr(12'h7fc, 32'h1, `MSE_RESP_SLVERR);
        rd(`MSE_ADDR_DMA_SEG, 32'h2a, `MSE_RESP_OKAY);
        foreach (pg[i]) xl(mse_pkg::MSE_ACC_DATA, {2'(i), 14'h2b5e}, 1'b0, {pg[i], 14'h2b5e});
        xl(mse_pkg::MSE_ACC_DMA, 16'h1234, 1'b1, {6'h2a, 16'h1234});
        xl(mse_pkg::MSE_ACC_DMA, 16'h1234, 1'b0, {6'h15, 16'h1234});
        xl(mse_pkg::MSE_ACC_DMA, 16'hfedc, 1'b1, {6'h2a, 16'hfedc});
        core.strobe(3'b100, 6'h3c);
        xl(mse_pkg::MSE_ACC_FETCH, 16'habcd, 1'b0, {6'h3c, 16'habcd});
        $display("test translate done");
        core.strobe(3'b010, 6'h00);
        chk(32'(push_seg_valid), 32'h0);
        chk(32'(context_state), 32'(mse_pkg::MSE_CTX_COMPAT));
        chk(32'(vector_base), 32'h150000);
        rd(`MSE_ADDR_STATUS, 32'h1, `MSE_RESP_OKAY);
        wr(`MSE_ADDR_CODE_SEG, 32'h09, `MSE_RESP_OKAY);
        rd(`MSE_ADDR_CODE_SEG, 32'h09, `MSE_RESP_OKAY);
        core.strobe(3'b100, 6'h01);
        xl(mse_pkg::MSE_ACC_FETCH, 16'h0100, 1'b0, {6'h15, 16'h0100});
        xl(mse_pkg::MSE_ACC_DATA, 16'h8001, 1'b0, {pg[2], 14'h0001});
        core.strobe(3'b001, 6'h33);
        chk(32'(context_state), 32'(mse_pkg::MSE_CTX_NORMAL));
        xl(mse_pkg::MSE_ACC_FETCH, 16'h0200, 1'b0, {6'h01, 16'h0200});
        $display("test compatible done");
        wr(`MSE_ADDR_EXT_MODE, 32'h40, `MSE_RESP_OKAY);
        core.strobe(3'b010, 6'h00);
        chk(32'(push_seg_valid), 32'h1);
        chk(32'(push_seg), 32'h01);
        xl(mse_pkg::MSE_ACC_FETCH, 16'h0300, 1'b0, {6'h15, 16'h0300});
        core.strobe(3'b100, 6'h07);
        xl(mse_pkg::MSE_ACC_FETCH, 16'h0400, 1'b0, {6'h07, 16'h0400});
        xl(mse_pkg::MSE_ACC_DATA, 16'h4002, 1'b0, {pg[1], 14'h0002});
        wr(`MSE_ADDR_HIGH_BANK + 12'h00c, 32'h77, `MSE_RESP_OKAY);
        xl(mse_pkg::MSE_ACC_DATA, 16'hc000, 1'b0, {8'h77, 14'h0000});
        wr(`MSE_ADDR_HIGH_BANK + 12'h00c, 32'(pg[3]), `MSE_RESP_OKAY);
        core.strobe(3'b001, 6'h01);
        xl(mse_pkg::MSE_ACC_FETCH, 16'h0500, 1'b0, {6'h01, 16'h0500});
        $display("test extended done");
        wr(`MSE_ADDR_EXT_MODE, 32'h20, `MSE_RESP_OKAY);
        rd(`MSE_ADDR_LOW_BANK, 32'(pg[0]), `MSE_RESP_OKAY);
        rd(`MSE_ADDR_HIGH_BANK, 32'h0, `MSE_RESP_OKAY);
        wr(`MSE_ADDR_HIGH_BANK, 32'h5a, `MSE_RESP_OKAY);
        xl(mse_pkg::MSE_ACC_DATA, 16'h0003, 1'b0, {pg[0], 14'h0003});
        wr(`MSE_ADDR_EXT_MODE, 32'h0, `MSE_RESP_OKAY);
        rd(`MSE_ADDR_HIGH_BANK, 32'(pg[0]), `MSE_RESP_OKAY);
        rd(`MSE_ADDR_LOW_BANK, 32'h5a, `MSE_RESP_OKAY);
        s_wstrb <= 4'he;
        wr(`MSE_ADDR_DMA_SEG, 32'h3f, `MSE_RESP_OKAY);
        s_wstrb <= 4'hf;
        rd(`MSE_ADDR_DMA_SEG, 32'h2a, `MSE_RESP_OKAY);
        $display("test remap done");
        wrap_up();
    end
endmodule
